// ===== rtl/hsrp_regs.svh
`ifndef HSRP_REGS_SVH
`define HSRP_REGS_SVH

// Two-wire target address, upper six bits fixed, LSB from the select pin
`define HSRP_TGT_ADDR_BASE  7'h68
// Register that stops the pointer from advancing
`define HSRP_FIFO_DATA_REG  8'h0c
// Pointer value after a plain START with a read address
`define HSRP_PTR_RESET      8'h00
// Four-wire command byte that selects a read
`define HSRP_SPI_CMD_READ   8'h80
// Four-wire framing
`define HSRP_SPI_HDR_BITS   16
`define HSRP_SPI_WORD_BITS  24
`define HSRP_SAMPLE_TAG_W   4
`define HSRP_SAMPLE_DATA_W  20
// Two-wire timing: fastest controller clock against the system clock
`define HSRP_SCL_MIN_PERIOD_NS 2500
`define HSRP_CLK_PERIOD_NS     50
`define HSRP_SCL_MIN_CYCLES    8

`endif

// ===== rtl/hsrp_pkg.sv
package hsrp_pkg;

  // Two-wire target sequencer states
  typedef enum logic [4:0] {
    HSRP_ST_IDLE = 5'h01,
    HSRP_ST_RX   = 5'h02,
    HSRP_ST_ACK  = 5'h04,
    HSRP_ST_TX   = 5'h08,
    HSRP_ST_RACK = 5'h10
  } hsrp_state_t;

  // Role of the byte being received
  typedef enum logic [1:0] {
    HSRP_BYTE_ADDR = 2'h0,
    HSRP_BYTE_PTR  = 2'h1,
    HSRP_BYTE_DATA = 2'h2
  } hsrp_byte_t;

endpackage : hsrp_pkg

// ===== rtl/hsrp_sync.sv
`timescale 1ns/10ps
`default_nettype none

module hsrp_sync
  import hsrp_pkg::*;
#(
  parameter int                 WIDTH = 1,
  parameter logic [WIDTH-1:0]   INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("hsrp_sync: WIDTH must be at least 1");
  end

  // Two stages; only the second stage is visible outside
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else if (en) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : hsrp_sync

`default_nettype wire

// ===== rtl/hsrp_spi.sv
`timescale 1ns/10ps
`default_nettype none
`include "hsrp_regs.svh"

module hsrp_spi
  import hsrp_pkg::*;
(
  input  wire logic        sclk,
  input  wire logic        chip_select_n,
  input  wire logic        sdi,
  input  wire logic [7:0]  spi_reg_rdata,
  input  wire logic [23:0] word_data,
  input  wire logic        word_valid,
  output logic      [7:0]  spi_reg_addr,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             word_taken
);

  logic [14:0] shift_in;
  logic [4:0]  hdr_cnt;
  logic        hdr_done;
  logic        burst;
  logic        rd_mode;
  logic [4:0]  wcnt;
  logic [23:0] out_sr;
  logic        drive;
  logic        valid_s;
  logic [4:0]  bit_idx;

  // Chip select high holds the whole link in reset, which also covers two-wire mode
  hsrp_sync #(.WIDTH(1), .INIT(1'b0)) u_valid_sync (
    .clk    (sclk),
    .arst_n (!chip_select_n),
    .en     (1'b1),
    .d      (word_valid),
    .q      (valid_s)
  );

  assign spi_reg_addr = shift_in[14:7];
  assign bit_idx      = 5'd23 - wcnt;
  assign sdo_oe       = drive & !chip_select_n;

  // Header shift, fetch at the sixteenth rising edge, word reloads
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      shift_in   <= 15'h0000;
      hdr_cnt    <= 5'h00;
      hdr_done   <= 1'b0;
      burst      <= 1'b0;
      rd_mode    <= 1'b0;
      wcnt       <= 5'h00;
      out_sr     <= 24'h000000;
      word_taken <= 1'b0;
    end else if (!hdr_done) begin
      hdr_cnt <= hdr_cnt + 5'd1;
      if (hdr_cnt == 5'(`HSRP_SPI_HDR_BITS - 1)) begin
        hdr_done <= 1'b1;
        wcnt     <= 5'h00;
        if ({shift_in[6:0], sdi} == `HSRP_SPI_CMD_READ) begin
          rd_mode <= 1'b1;
          if (shift_in[14:7] == `HSRP_FIFO_DATA_REG) begin
            burst <= 1'b1;
            // An empty holding word reads back as zeros rather than stalling
            out_sr <= valid_s ? word_data : 24'h000000;
            if (valid_s) word_taken <= !word_taken;
          end else begin
            out_sr <= {spi_reg_rdata, 16'h0000};
          end
        end
      end else begin
        shift_in <= {shift_in[13:0], sdi};
      end
    end else if (wcnt == 5'(`HSRP_SPI_WORD_BITS - 1)) begin
      wcnt <= 5'h00;
      if (burst) begin
        out_sr <= valid_s ? word_data : 24'h000000;
        if (valid_s) word_taken <= !word_taken;
      end else begin
        out_sr <= 24'h000000; // Extra clocks on a single read return zeros
      end
    end else begin
      wcnt <= wcnt + 5'd1;
    end
  end

  // Launch on the falling edge so the host samples a settled bit
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      sdo   <= 1'b0;
      drive <= 1'b0;
    end else begin
      sdo   <= hdr_done & out_sr[bit_idx];
      drive <= hdr_done & rd_mode;
    end
  end

  burst_reload_a: assert property (@(posedge sclk) disable iff (chip_select_n)
    (hdr_done && burst && wcnt == 5'd23 && valid_s) |=> (word_taken != $past(word_taken)))
    else $error("burst word not reloaded after 24 clocks");

  hdr_length_a: assert property (@(posedge sclk) disable iff (chip_select_n)
    (hdr_cnt == 5'd15 && !hdr_done) |=> (hdr_done && wcnt == 5'd0))
    else $error("header did not end at sixteenth clock");

endmodule : hsrp_spi

`default_nettype wire

// ===== rtl/hsrp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "hsrp_regs.svh"

// What this block does
// - Burst read opens with sixteen clocks of address then read command.
// - After the command, FIFO words stream out, twenty-four clocks each.
// - Each sample is a 4-bit tag then 20 data bits, three bytes.
// - Two-wire target works with controller clocks up to 400 kHz.
// - Data line is input plus pull-low-only driver; clock is input only.
// - One bit per clock; data changes only while clock is low.
// - START is data falling, STOP data rising, both with clock high.
// - Repeated START keeps the transaction active, same waveform as START.
// - STOP honoured anywhere except after a START in the same clock-high.
// - Target address 0x68 or 0x69 from select pin, direction bit appended.
// - Target holds data low for the ninth pulse after good bytes.
// - Write frame: START, address, pointer byte, data bytes, STOP.
// - Pointer advances after each written data byte.
// - Pointer stays put when the write targets register 0x0c.
// - Plain START with read address sets the pointer to 0x00.
// - Pointer advances after each byte read, except at register 0x0c.
// - STOP may end a read anytime; next plain-START read begins at 0x00.
// - Pointer write, repeated START, read address returns that register.
// - Chip select high selects two-wire; low selects four-wire link.
// - Four-wire inputs sampled on rising clock, outputs launched on falling.
// - Four-wire read fetches at edge sixteen and drives MSB next fall.

module hsrp_top
  import hsrp_pkg::*;
#(
  parameter int TAG_W  = `HSRP_SAMPLE_TAG_W,
  parameter int DATA_W = `HSRP_SAMPLE_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              sclk,
  input  wire logic              chip_select_n,
  input  wire logic              sdi_sda_in,
  output logic                   sdi_sda_out,
  output logic                   sdi_sda_oe,
  input  wire logic              serial_out_or_id_select_pin_in,
  output logic                   serial_out_or_id_select_pin_out,
  output logic                   serial_out_or_id_select_pin_oe,
  output logic      [7:0]        reg_addr,
  output logic      [7:0]        reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [7:0]        reg_rdata,
  output logic      [7:0]        spi_reg_addr,
  input  wire logic [7:0]        spi_reg_rdata,
  input  wire logic [TAG_W-1:0]  fifo_tag,
  input  wire logic [DATA_W-1:0] fifo_data,
  input  wire logic              fifo_valid,
  output logic                   fifo_pop
);

  localparam int SCL_CYCLES = `HSRP_SCL_MIN_PERIOD_NS / `HSRP_CLK_PERIOD_NS;

  // The bit timing below needs several samples per controller clock
  initial begin
    if (TAG_W + DATA_W != `HSRP_SPI_WORD_BITS) $error("hsrp_top: sample must be 24 bits");
    if (SCL_CYCLES < `HSRP_SCL_MIN_CYCLES) $error("hsrp_top: clk too slow for 400 kHz");
  end

  // Pointer step that parks on the FIFO data register
  function automatic logic [7:0] step_ptr(input logic [7:0] p);
    step_ptr = (p == `HSRP_FIFO_DATA_REG) ? p : p + 8'd1;
  endfunction : step_ptr

  logic [3:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        i2c_sel;
  logic        id_sel;
  logic        scl_d;
  logic        sda_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        start_in_high;
  hsrp_state_t state;
  hsrp_byte_t  kind;
  logic [3:0]  bitcnt;
  logic [7:0]  rx_sr;
  logic [7:0]  tx_sr;
  logic [7:0]  ptr;
  logic        is_read;
  logic        rstart;
  logic        ctl_ack;
  logic        rd_q;
  logic        sda_drive;
  logic [23:0] word_hold;
  logic        word_valid;
  logic        taken_tgl;
  logic        taken_s;
  logic        taken_d;
  logic        spi_sdo;
  logic        spi_sdo_oe;

  // All pins cross into the clk domain through two flops; bus lines idle high
  hsrp_sync #(.WIDTH(4), .INIT(4'hf)) u_pin_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .en     (ce),
    .d      ({sclk, sdi_sda_in, chip_select_n, serial_out_or_id_select_pin_in}),
    .q      (pins_s)
  );

  assign scl_s   = pins_s[3];
  assign sda_s   = pins_s[2];
  assign i2c_sel = pins_s[1];
  assign id_sel  = pins_s[0];

  // Event toggle from the link domain
  hsrp_sync #(.WIDTH(1), .INIT(1'b0)) u_taken_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .en     (ce),
    .d      (taken_tgl),
    .q      (taken_s)
  );

  hsrp_spi u_spi (
    .sclk          (sclk),
    .chip_select_n (chip_select_n),
    .sdi           (sdi_sda_in),
    .spi_reg_rdata (spi_reg_rdata),
    .word_data     (word_hold),
    .word_valid    (word_valid),
    .spi_reg_addr  (spi_reg_addr),
    .sdo           (spi_sdo),
    .sdo_oe        (spi_sdo_oe),
    .word_taken    (taken_tgl)
  );

  // Shared pins: address select in two-wire mode, serial output in four-wire mode
  assign serial_out_or_id_select_pin_out = spi_sdo;
  assign serial_out_or_id_select_pin_oe  = spi_sdo_oe;

  // Open-drain data line only ever pulls low
  assign sdi_sda_out = 1'b0;
  assign sdi_sda_oe  = sda_drive & i2c_sel;

  // Line history for edge and condition detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      taken_d <= 1'b0;
    end else if (ce) begin
      scl_d   <= scl_s;
      sda_d   <= sda_s;
      taken_d <= taken_s;
    end
  end

  assign scl_rise  = scl_s & !scl_d;
  assign scl_fall  = !scl_s & scl_d;
  assign start_det = i2c_sel & scl_s & scl_d & sda_d & !sda_s;
  assign stop_det  = i2c_sel & scl_s & scl_d & !sda_d & sda_s & !start_in_high;

  // A STOP after a START in the same clock-high would be ambiguous, so it is dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_in_high <= 1'b0;
    end else if (ce) begin
      if (start_det) start_in_high <= 1'b1;
      else if (!scl_s) start_in_high <= 1'b0;
    end
  end

  // Holding word for the burst; refilled only once the link has taken it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word_hold  <= 24'h000000;
      word_valid <= 1'b0;
      fifo_pop   <= 1'b0;
    end else if (ce) begin
      fifo_pop <= 1'b0;
      // Chip select high returns the link-side toggle to zero; that is not a take
      if (taken_s != taken_d && !i2c_sel) begin
        word_valid <= 1'b0;
      end else if (!word_valid && fifo_valid && !fifo_pop) begin
        word_hold  <= {fifo_tag, fifo_data};
        word_valid <= 1'b1;
        fifo_pop   <= 1'b1;
      end
    end
  end

  // Two-wire target sequencer; data moves only around clock edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= HSRP_ST_IDLE;
      kind      <= HSRP_BYTE_ADDR;
      bitcnt    <= 4'h0;
      rx_sr     <= 8'h00;
      tx_sr     <= 8'h00;
      ptr       <= `HSRP_PTR_RESET;
      is_read   <= 1'b0;
      rstart    <= 1'b0;
      ctl_ack   <= 1'b0;
      rd_q      <= 1'b0;
      sda_drive <= 1'b0;
      reg_addr  <= 8'h00;
      reg_wdata <= 8'h00;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
    end else if (ce) begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      rd_q   <= reg_rd;
      if (rd_q) tx_sr <= reg_rdata;
      if (!i2c_sel) begin
        state     <= HSRP_ST_IDLE;
        sda_drive <= 1'b0;
      end else if (start_det) begin
        rstart    <= (state != HSRP_ST_IDLE);
        state     <= HSRP_ST_RX;
        kind      <= HSRP_BYTE_ADDR;
        bitcnt    <= 4'h0;
        sda_drive <= 1'b0;
      end else if (stop_det) begin
        state     <= HSRP_ST_IDLE;
        sda_drive <= 1'b0;
      end else begin
        case (state)
          HSRP_ST_IDLE: begin
            sda_drive <= 1'b0;
          end
          HSRP_ST_RX: begin
            if (scl_rise && bitcnt != 4'd8) begin
              rx_sr  <= {rx_sr[6:0], sda_s};
              bitcnt <= bitcnt + 4'd1;
            end else if (scl_fall && bitcnt == 4'd8) begin
              bitcnt <= 4'h0;
              state  <= HSRP_ST_ACK;
              sda_drive <= 1'b1;
              case (kind)
                HSRP_BYTE_ADDR: begin
                  if (rx_sr[7:1] == (`HSRP_TGT_ADDR_BASE | {6'h00, id_sel})) begin
                    is_read <= rx_sr[0];
                    if (rx_sr[0] && !rstart) ptr <= `HSRP_PTR_RESET;
                  end else begin
                    state     <= HSRP_ST_IDLE;
                    sda_drive <= 1'b0;
                  end
                end
                HSRP_BYTE_PTR: begin
                  ptr <= rx_sr;
                end
                default: begin
                  reg_addr  <= ptr;
                  reg_wdata <= rx_sr;
                  reg_wr    <= 1'b1;
                  ptr       <= step_ptr(ptr);
                end
              endcase
            end
          end
          HSRP_ST_ACK: begin
            if (scl_rise && is_read) begin
              reg_addr <= ptr;
              reg_rd   <= 1'b1;
            end else if (scl_fall) begin
              if (is_read) begin
                state     <= HSRP_ST_TX;
                sda_drive <= !tx_sr[7];
                tx_sr     <= {tx_sr[6:0], 1'b0};
                bitcnt    <= 4'd1;
              end else begin
                state     <= HSRP_ST_RX;
                sda_drive <= 1'b0;
                kind      <= (kind == HSRP_BYTE_ADDR) ? HSRP_BYTE_PTR : HSRP_BYTE_DATA;
              end
            end
          end
          HSRP_ST_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'd8) begin
                state     <= HSRP_ST_RACK;
                sda_drive <= 1'b0;
                ptr       <= step_ptr(ptr);
              end else begin
                sda_drive <= !tx_sr[7];
                tx_sr     <= {tx_sr[6:0], 1'b0};
                bitcnt    <= bitcnt + 4'd1;
              end
            end
          end
          HSRP_ST_RACK: begin
            if (scl_rise) begin
              ctl_ack <= !sda_s;
              if (!sda_s) begin
                reg_addr <= ptr;
                reg_rd   <= 1'b1;
              end
            end else if (scl_fall) begin
              if (ctl_ack) begin
                state     <= HSRP_ST_TX;
                sda_drive <= !tx_sr[7];
                tx_sr     <= {tx_sr[6:0], 1'b0};
                bitcnt    <= 4'd1;
              end else begin
                state <= HSRP_ST_IDLE; // Not-acknowledge: wait for STOP or START
              end
            end
          end
          default: begin
            state     <= HSRP_ST_IDLE;
            sda_drive <= 1'b0;
          end
        endcase
      end
    end
  end

  ack_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == HSRP_ST_ACK && scl_rise && ce) |-> sda_drive)
    else $error("acknowledge not held through ninth pulse");

  fifo_park_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr == 8'h0c) |-> (ptr == 8'h0c))
    else $error("pointer moved off FIFO data register");

  write_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr != 8'h0c) |-> (ptr == reg_addr + 8'd1))
    else $error("pointer did not advance after write");

  start_seen_a: assert property (@(posedge clk) disable iff (!arst_n)
    (start_det && ce) |=> (state == HSRP_ST_RX && bitcnt == 4'h0))
    else $error("START not taken");

  stop_seen_a: assert property (@(posedge clk) disable iff (!arst_n)
    (stop_det && !start_det && ce) |=> (state == HSRP_ST_IDLE && !sda_drive))
    else $error("STOP not honoured");

  mode_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    sdi_sda_oe |-> i2c_sel)
    else $error("data line driven outside two-wire mode");

  tx_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == HSRP_ST_TX && $changed(sda_drive)) |-> $past(scl_fall))
    else $error("read data changed away from clock fall");

  read_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state == HSRP_ST_TX && scl_fall && bitcnt == 4'd8 && ce && !start_det && !stop_det)
    |=> (ptr == (($past(ptr) == 8'h0c) ? 8'h0c : $past(ptr) + 8'd1)))
    else $error("pointer step after read byte wrong");

endmodule : hsrp_top

`default_nettype wire

// ===== tb/hsrp_host.sv
`timescale 1ns/10ps
`default_nettype none

module hsrp_host #(
  parameter int Q = 650
) (
  output logic      scl,
  output logic      sda_low,
  output logic      sdi,
  output logic      cs_n,
  output logic      addr_sel,
  input  wire logic sda,
  input  wire logic sdo
);
  // Lines idle released and high, two-wire link selected
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
    addr_sel = 1'b0;
  end

  // START or repeated START; data released before clock rises so a repeat is legal mid-frame
  task automatic i2c_start;
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask : i2c_start

  // STOP raises its own clock-high pulse and leaves the clock high, so a following START shares that pulse
  task automatic i2c_stop;
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask : i2c_stop

  // Byte MSB first, then ninth bit; quarter period 650 ns keeps SCL near 385 kHz
  task automatic i2c_byte(input logic [7:0] b, input logic nb,
                          output logic [7:0] got, output logic ack);
    logic [8:0] s;
    logic       r;
    s = {b, nb};
    for (int i = 8; i >= 0; i--) begin
      sda_low = ~s[i];
      #Q;
      scl = 1'b1;
      #Q;
      r = sda;
      #Q;
      r = r | sda; // Either sample high means the line was not held low
      scl = 1'b0;
      #Q;
      if (i > 0) begin
        got[i-1] = r;
      end else begin
        ack = r;
      end
    end
  endtask : i2c_byte

  // Four-wire frame: header on rises, reply sampled on rises, clock still outside
  task automatic spi_frame(input logic [15:0] hdr, input int n, output logic [47:0] got);
    scl = 1'b0;
    #20;
    cs_n = 1'b0;
    #20;
    for (int i = 15; i >= 0; i--) begin
      sdi = hdr[i];
      #7.5;
      scl = 1'b1;
      #7.5;
      scl = 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      sdi = ~sdi; // Toggling input so nothing leans on a stale level
      #7.5;
      scl = 1'b1;
      got = {got[46:0], sdo};
      #7.5;
      scl = 1'b0;
    end
    #20;
    cs_n = 1'b1;
    #20;
    scl = 1'b1;
  endtask : spi_frame
endmodule : hsrp_host

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import hsrp_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce = 1'b1;
  logic        h_scl, h_sda_low, h_sdi, h_cs_n, h_sel;
  logic        sda_out, sda_oe, id_out, id_oe, reg_wr, reg_rd, fifo_pop;
  logic [7:0]  reg_addr, reg_wdata, spi_reg_addr;
  logic [7:0]  reg_rdata = 8'h00;
  logic [3:0]  fifo_tag = 4'h0;
  logic [19:0] fifo_data = 20'h0;
  logic        fifo_valid = 1'b0;
  logic [7:0]  mem [256];
  logic [15:0] wlog [$];
  logic [23:0] fq [$];
  logic [7:0]  g;
  logic        a;
  logic [47:0] sg;
  logic        oe_in_spi = 1'b0;
  int          err_count = 0;
  int          checked = 0;
  // Open-drain data line with pull-up; data pin muxed by chip select, select pin by its output enable
  wire logic   sda_w = ~(h_sda_low | (sda_oe & ~sda_out));
  wire logic   sdi_in = h_cs_n ? sda_w : h_sdi;
  wire logic   id_w = id_oe ? id_out : h_sel;
  wire logic [7:0] spi_rdata = spi_reg_addr ^ 8'h5a;

  always #25 clk = ~clk;

  hsrp_host host (.scl(h_scl), .sda_low(h_sda_low), .sdi(h_sdi), .cs_n(h_cs_n),
                  .addr_sel(h_sel), .sda(sda_w), .sdo(id_w));

  hsrp_top DUT (.clk(clk), .arst_n(arst_n), .ce(ce), .sclk(h_scl), .chip_select_n(h_cs_n),
    .sdi_sda_in(sdi_in), .sdi_sda_out(sda_out), .sdi_sda_oe(sda_oe),
    .serial_out_or_id_select_pin_in(id_w), .serial_out_or_id_select_pin_out(id_out),
    .serial_out_or_id_select_pin_oe(id_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_reg_addr(spi_reg_addr),
    .spi_reg_rdata(spi_rdata), .fifo_tag(fifo_tag), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_pop(fifo_pop));

  // Register file and FIFO head model, updated off the sampling edge
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hc3;
  always @(negedge clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] = reg_wdata;
      wlog.push_back({reg_addr, reg_wdata});
    end
    if (reg_rd === 1'b1) reg_rdata = mem[reg_addr];
    if (fifo_pop === 1'b1 && fq.size() > 0) void'(fq.pop_front());
    fifo_valid = fq.size() > 0;
    {fifo_tag, fifo_data} = fifo_valid ? fq[0] : 24'h0;
  end
  // Two-wire driver must stay off while the four-wire link is chosen
  always @(posedge clk) if (!h_cs_n && sda_oe === 1'b1) oe_in_spi <= 1'b1;

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Controller writes a byte and expects the target to hold the ninth pulse low
  task automatic wb(input logic [7:0] b);
    host.i2c_byte(b, 1'b1, g, a);
    check("ack", 48'(a), 48'h0);
  endtask : wb

  // Controller reads a byte and answers with ACK or final NACK
  task automatic rb(input logic [7:0] e, input logic nb);
    host.i2c_byte(8'hff, nb, g, a);
    check("rdata", 48'(g), 48'(e));
  endtask : rb

  // Both select levels against both addresses: only the matching one is answered
  task automatic t_addr;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 2; k++) begin
        host.addr_sel = s[0];
        host.i2c_start();
        host.i2c_byte({6'h34, k[0], 1'b0}, 1'b1, g, a);
        check("addr ack", 48'(a), 48'(k != s));
        host.i2c_stop();
      end
    end
    host.addr_sel = 1'b0;
  endtask : t_addr

  // Plain-START reads begin at 0x00 and advance; a later read restarts at 0x00
  task automatic t_read_plain;
    host.i2c_start();
    wb(8'hd1);
    rb(8'hc3, 1'b0);
    rb(8'hc2, 1'b0);
    rb(8'hc1, 1'b1);
    host.i2c_stop();
    host.i2c_start();
    wb(8'hd1);
    rb(8'hc3, 1'b1);
    host.i2c_stop();
  endtask : t_read_plain

  // Pointer preset then repeated START; pointer sticks on the FIFO data register
  task automatic t_read_preset;
    host.i2c_start();
    wb(8'hd0);
    wb(8'h0b);
    host.i2c_start();
    wb(8'hd1);
    rb(8'hc8, 1'b0);
    rb(8'hcf, 1'b0);
    rb(8'hcf, 1'b1);
    host.i2c_stop();
  endtask : t_read_preset

  // Multi-byte write crossing into 0x0c, where the pointer stops advancing
  task automatic t_write;
    wlog.delete();
    host.i2c_start();
    wb(8'hd0);
    wb(8'h0b);
    wb(8'ha1);
    wb(8'ha2);
    wb(8'ha3);
    host.i2c_stop();
    repeat (4) @(negedge clk);
    check("writes", 48'(wlog.size()), 48'd3);
    check("write0", 48'(wlog[0]), 48'h0ba1);
    check("write1", 48'(wlog[1]), 48'h0ca2);
    check("write2", 48'(wlog[2]), 48'h0ca3);
  endtask : t_write

  // Burst of two tagged words, then a single read padded with zeros
  task automatic t_spi;
    fq.push_back(24'h3abcde);
    fq.push_back(24'h91234f);
    repeat (4) @(negedge clk);
    host.spi_frame(16'h0c80, 48, sg);
    check("burst", sg, 48'h3abcde91234f);
    check("sdo oe", 48'(id_oe), 48'h0);
    check("fifo drained", 48'(fifo_valid), 48'h0);
    host.spi_frame(16'h2180, 16, sg);
    check("single", 48'(sg[15:0]), 48'h7b00);
    check("two-wire idle", 48'(oe_in_spi), 48'h0);
    repeat (4) @(negedge clk);
  endtask : t_spi

  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_addr();
    t_read_plain();
    t_spi();
    t_read_preset();
    t_write();
    summarize();
  end
endmodule : tb

`default_nettype wire
